/* File: inc/tx_pcs_if.sv */
// carriers between the front end, its encoder and its buffer memory
`timescale 1ns/1ps
interface enc_link_if;
  logic        enable;
  logic        valid_in;
  logic [63:0] data;
  logic [7:0]  k;
  logic [7:0]  skip;
  logic [7:0]  sel;
  logic [7:0]  val;
  logic [7:0]  lanes;
  logic [79:0] groups;
  logic        valid_out;
  modport user  (output enable, valid_in, data, k, skip, sel, val, lanes,
                 input groups, valid_out);
  modport coder (input enable, valid_in, data, k, skip, sel, val, lanes,
                 output groups, valid_out);
endinterface

interface buf_mem_if #(parameter int W = 80, parameter int AW = 3);
  logic          we;
  logic          re;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [W-1:0]  wdata;
  logic [W-1:0]  rdata;
  modport ctrl (output we, re, waddr, raddr, wdata, input rdata);
  modport mem  (input we, re, waddr, raddr, wdata, output rdata);
endinterface

/* File: inc/tx_pcs_pkg.sv */
// constants, types and helpers shared by the transmit pcs front end
package tx_pcs_pkg;
  localparam int LANES = 8;
  localparam int GRP = 10;
  localparam int WORD = 80;
  localparam int DRV_FIELDS = 12;
  localparam int DRV_W = 7;
  localparam int SETS = 3;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] SET_NORMAL = 2'h0;
  localparam logic [1:0] SET_IDLE = 2'h1;
  localparam logic [1:0] SET_DETECT = 2'h2;
  localparam logic [7:0] ADDR_WIDTH_SEL = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h31;
  localparam logic [3:0] F_CM_LOWER = 4'ha;
  localparam logic [3:0] F_CM_UPPER = 4'hb;
  localparam logic [1:0] WIDTH_SEL_RESET = 2'h3;
  localparam logic RD_RESET = 1'b0;
  localparam logic [14:0] PRBS_SEED = 15'h7fff;
  localparam logic [DRV_W-1:0] DRV_RESET [DRV_FIELDS] = '{
    7'h00, 7'h00, 7'h0f, 7'h00, 7'h3f, 7'h00,
    7'h04, 7'h3f, 7'h00, 7'h00, 7'h0e, 7'h10};
  localparam logic [DRV_W-1:0] DRV_MASK [DRV_FIELDS] = '{
    7'h1f, 7'h1f, 7'h1f, 7'h1f, 7'h3f, 7'h1f,
    7'h07, 7'h7f, 7'h1f, 7'h1f, 7'h1f, 7'h1f};

  typedef enum logic [2:0] {
    PAT_OFF    = 3'h0,
    PAT_PRBS7  = 3'h1,
    PAT_PRBS15 = 3'h2,
    PAT_RSV3   = 3'h3,
    PAT_RSV4   = 3'h4,
    PAT_RSV5   = 3'h5,
    PAT_SQ2    = 3'h6,
    PAT_SQWORD = 3'h7
  } pattern_t;

  function automatic logic [7:0] lane_mask(logic [1:0] sel);
    return sel[1] ? 8'hff : (sel[0] ? 8'h0f : 8'h03);
  endfunction

  function automatic logic [6:0] word_bits(logic [1:0] sel);
    return sel[1] ? 7'h50 : (sel[0] ? 7'h28 : 7'h14);
  endfunction
endpackage

/* File: logic/serdes_tx_pcs_front_end.sv */
// transmit pcs front end: lane mapping, coding, patterns, buffer, config
//
// Behaviour
// [R1] raw mode: group bits 7:0 data byte, bit 8 value, bit 9 select
// [R2] groups go out lowest lane first; 2, 4 or 8 lanes by width
// [R3] encoder used only while the encoder enable input is high
// [R4] each high skip bit passes its byte around the encoder unencoded
// [R5] each high control flag encodes its byte as a K character
// [R6] skip bit n and control bit n both act on data byte n
// [R7] select bit chooses whether value bit overrides running disparity
// [R8] 00 running, 01 inverted, 10 force negative, 11 force positive
// [R9] encoder stage adds a cycle and drops out when disabled
// [R10] a phase-adjust buffer sits between pcs side and pma side
// [R11] buffer overflow or underflow sets a sticky error output
// [R12] that error clears only by the two transmit resets
// [R13] error readable as a status bit that reads 0 after reset
// [R14] pattern select: off, prbs7, prbs15, reserved, 2 UI, word square
// [R15] error inject input flips bits of the transmitted prbs
// [R16] polarity 0 passes data, 1 inverts every outgoing bit
// [R17] software keeps cursor counts within their branch counts
// [R18] equal common-mode setpoints switch the regulation loop off
// [R19] a duplicate driver set applies during electrical idle
// [R20] a third driver set applies during receiver detection
// [R21] width select 00 20 bits, 01 40 bits, 1x 80 bits
// [R22] raw mode takes 64 data bits plus the two 8-bit extensions
// [R23] standard code tables, disparity carried across bytes and lanes
`timescale 1ns/1ps
module serdes_tx_pcs_front_end #(
  parameter int DEPTH = tx_pcs_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tx_reset,
  input  wire logic        clk_en,
  input  wire logic [63:0] tx_data,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  disparity_override_select,
  input  wire logic [7:0]  disparity_override_value,
  input  wire logic [7:0]  per_byte_encoder_skip,
  input  wire logic        encoder_enable_in,
  input  wire logic [7:0]  control_char_flag,
  input  wire logic [2:0]  pattern_select,
  input  wire logic        pattern_error_inject,
  input  wire logic        polarity_invert,
  input  wire logic        electrical_idle,
  input  wire logic        receiver_detect,
  input  wire logic        pma_take,
  input  wire logic        reg_we,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  output      logic [79:0] pma_word,
  output      logic        pma_valid,
  output      logic        tx_buf_err,
  output      logic [83:0] driver_settings,
  output      logic [1:0]  active_set,
  output      logic        cm_regulation_en
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("buffer depth must be a power of two, at least 2");
  end

  // reset: async assert from either transmit reset, sync release
  logic       arst_b;
  logic [1:0] rst_sync;
  logic       rst_int_b;

  assign arst_b = rst_b & ~tx_reset; // [R12]

  always_ff @(posedge clk or negedge arst_b) begin
    if (!arst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_int_b = rst_sync[1];

  // register file
  logic [6:0] drv_reg [tx_pcs_pkg::SETS][tx_pcs_pkg::DRV_FIELDS];
  logic [1:0] width_sel_reg;
  logic       err_reg;
  logic [1:0] set_sel;
  logic [1:0] set_next;

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      for (int s = 0; s < tx_pcs_pkg::SETS; s++) begin
        for (int f = 0; f < tx_pcs_pkg::DRV_FIELDS; f++) begin
          drv_reg[s][f] <= tx_pcs_pkg::DRV_RESET[f];
        end
      end
    end else if (clk_en && reg_we && reg_addr[7:6] == 2'h0
                 && reg_addr[5:4] != 2'h3
                 && reg_addr[3:0] < 4'hc) begin
      drv_reg[reg_addr[5:4]][reg_addr[3:0]] <=
        reg_wdata[6:0] & tx_pcs_pkg::DRV_MASK[reg_addr[3:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      width_sel_reg <= tx_pcs_pkg::WIDTH_SEL_RESET;
    end else if (clk_en && reg_we
                 && reg_addr == tx_pcs_pkg::ADDR_WIDTH_SEL) begin
      width_sel_reg <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_addr == tx_pcs_pkg::ADDR_STATUS) begin
        reg_rdata <= {7'h00, err_reg}; // [R13]
      end else if (reg_addr == tx_pcs_pkg::ADDR_WIDTH_SEL) begin
        reg_rdata <= {6'h00, width_sel_reg};
      end else if (reg_addr[7:6] == 2'h0 && reg_addr[5:4] != 2'h3
                   && reg_addr[3:0] < 4'hc) begin
        reg_rdata <= {1'b0, drv_reg[reg_addr[5:4]][reg_addr[3:0]]};
      end
    end
  end

  // driver set in force
  always_comb begin
    if (receiver_detect) begin
      set_next = tx_pcs_pkg::SET_DETECT; // [R20]
    end else if (electrical_idle) begin
      set_next = tx_pcs_pkg::SET_IDLE; // [R19]
    end else begin
      set_next = tx_pcs_pkg::SET_NORMAL;
    end
  end

  assign set_sel = set_next;

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      driver_settings <= '0;
      active_set <= tx_pcs_pkg::SET_NORMAL;
      cm_regulation_en <= 1'b0;
    end else if (clk_en) begin
      active_set <= set_sel;
      for (int f = 0; f < tx_pcs_pkg::DRV_FIELDS; f++) begin
        driver_settings[f*7 +: 7] <= drv_reg[set_sel][f]; // [R19] [R20]
      end
      cm_regulation_en <= drv_reg[set_sel][tx_pcs_pkg::F_CM_LOWER]
                       != drv_reg[set_sel][tx_pcs_pkg::F_CM_UPPER]; // [R18]
    end
  end

  // lane mapping and encoder
  logic [7:0]  lanes;
  logic [6:0]  nbits;
  logic [79:0] raw_groups;
  logic [79:0] data_groups;
  logic        data_valid;

  enc_link_if enc ();

  assign lanes = tx_pcs_pkg::lane_mask(width_sel_reg); // [R21] [R2]
  assign nbits = tx_pcs_pkg::word_bits(width_sel_reg); // [R21]

  always_comb begin
    raw_groups = '0;
    for (int n = 0; n < tx_pcs_pkg::LANES; n++) begin
      if (lanes[n]) begin
        raw_groups[n*10 +: 10] = {disparity_override_select[n],
                                  disparity_override_value[n],
                                  tx_data[n*8 +: 8]}; // [R1] [R22] [R2]
      end
    end
  end

  assign enc.enable = encoder_enable_in;
  assign enc.valid_in = tx_valid;
  assign enc.data = tx_data;
  assign enc.k = control_char_flag;
  assign enc.skip = per_byte_encoder_skip;
  assign enc.sel = disparity_override_select;
  assign enc.val = disparity_override_value;
  assign enc.lanes = lanes;

  tx_8b10b_coder tx_8b10b_coder_i (
    .clk    (clk),
    .rst_b  (rst_int_b),
    .clk_en (clk_en),
    .e      (enc.coder)
  );

  // encoded path only while enabled, else raw groups pass straight on
  assign data_groups = encoder_enable_in ? enc.groups
                                         : raw_groups; // [R3] [R9]
  assign data_valid = encoder_enable_in ? enc.valid_out
                                        : tx_valid; // [R3] [R9]

  // pattern generator
  logic [14:0] lfsr_reg;
  logic [94:0] prbs_out;
  logic [79:0] pat_word;
  logic [79:0] word_mask;
  logic        pat_on;
  logic        pat_prbs;
  logic [79:0] src_word;
  logic        wr_req;

  function automatic logic [94:0] prbs_run(logic [14:0] s, logic long,
                                           logic [6:0] n);
    logic [14:0] st;
    logic [79:0] w;
    logic        fb;
    st = s;
    w = '0;
    fb = 1'b0;
    for (int i = 0; i < 80; i++) begin
      if (i < n) begin
        fb = long ? (st[14] ^ st[13]) : (st[6] ^ st[5]);
        st = {st[13:0], fb};
        w[i] = fb;
      end
    end
    return {st, w};
  endfunction

  assign prbs_out = prbs_run(lfsr_reg,
                             pattern_select == tx_pcs_pkg::PAT_PRBS15,
                             nbits);
  assign pat_prbs = pattern_select == tx_pcs_pkg::PAT_PRBS7
                 || pattern_select == tx_pcs_pkg::PAT_PRBS15;
  assign pat_on = pattern_select != tx_pcs_pkg::PAT_OFF;

  always_comb begin
    word_mask = '0;
    for (int i = 0; i < 80; i++) begin
      word_mask[i] = i < nbits;
    end
  end

  always_comb begin
    pat_word = '0;
    unique case (pattern_select)
      tx_pcs_pkg::PAT_PRBS7,
      tx_pcs_pkg::PAT_PRBS15: begin
        pat_word = prbs_out[79:0]; // [R14]
        pat_word[0] = prbs_out[0] ^ pattern_error_inject; // [R15]
      end
      tx_pcs_pkg::PAT_SQ2: pat_word = {40{2'b10}}; // [R14]
      tx_pcs_pkg::PAT_SQWORD: begin
        for (int i = 0; i < 80; i++) begin
          pat_word[i] = i < (nbits >> 1); // [R14]
        end
      end
      default: pat_word = '0;
    endcase
  end

  assign wr_req = pat_on ? 1'b1 : data_valid;
  assign src_word = ((pat_on ? pat_word : data_groups)
                    ^ {80{polarity_invert}}) & word_mask; // [R16]

  // phase-adjust buffer
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic        full;
  logic        empty;
  logic        do_wr;
  logic        do_rd;
  logic        rd_q;
  logic        overflow;
  logic        underflow;

  buf_mem_if #(.W(tx_pcs_pkg::WORD), .AW(AW)) bm ();

  assign empty = wptr_reg == rptr_reg;
  assign full = wptr_reg == {~rptr_reg[AW], rptr_reg[AW-1:0]};
  assign do_rd = pma_take && !empty;
  // pattern words wait for room; fabric words are lost when full
  assign do_wr = wr_req && (!full || do_rd);
  assign overflow = wr_req && !pat_on && full && !do_rd; // [R11]
  assign underflow = pma_take && empty; // [R11]

  assign bm.we = clk_en && do_wr; // [R10]
  assign bm.re = clk_en && do_rd; // [R10]
  assign bm.waddr = wptr_reg[AW-1:0];
  assign bm.raddr = rptr_reg[AW-1:0];
  assign bm.wdata = src_word;

  tx_buf_mem #(.W(tx_pcs_pkg::WORD), .DEPTH(DEPTH)) tx_buf_mem_i (
    .clk    (clk),
    .clk_en (clk_en),
    .m      (bm.mem)
  );

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (clk_en) begin
      if (do_wr) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_rd) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      lfsr_reg <= tx_pcs_pkg::PRBS_SEED;
    end else if (clk_en && pat_prbs && do_wr) begin
      lfsr_reg <= prbs_out[94:80];
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      rd_q <= 1'b0;
      pma_valid <= 1'b0;
      pma_word <= '0;
    end else if (clk_en) begin
      rd_q <= do_rd;
      pma_valid <= rd_q;
      if (rd_q) begin
        pma_word <= bm.rdata; // [R2]
      end
    end
  end

  // sticky buffer error, only the resets clear it
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      err_reg <= 1'b0; // [R12]
    end else if (clk_en && (overflow || underflow)) begin
      err_reg <= 1'b1; // [R11]
    end
  end

  assign tx_buf_err = err_reg; // [R11] [R13]
endmodule

/* File: logic/tx_8b10b_coder.sv */
// registered 8b/10b encoder stage with per-byte disparity control
`timescale 1ns/1ps
module tx_8b10b_coder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  enc_link_if.coder e
);
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  // returns {disparity after, code}; code bit 0 goes on the line first
  function automatic logic [10:0] enc_byte(logic [7:0] d, logic k,
                                           logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] code;
    logic       k28;
    logic       rdm;
    logic       a7;
    logic       flip4;
    k28 = k && (d[4:0] == 5'h1c);
    c6 = k28 ? 6'h0f : T6[d[4:0]];
    if (rd && (($countones(c6) != 3) || (c6 == 6'h38))) begin
      c6 = ~c6;
    end
    rdm = rd ^ ($countones(c6) != 3);
    a7 = (d[7:5] == 3'h7) && (k
         || (!rdm && (d[4:0] == 5'h11 || d[4:0] == 5'h12
                      || d[4:0] == 5'h14))
         || (rdm && (d[4:0] == 5'h0b || d[4:0] == 5'h0d
                     || d[4:0] == 5'h0e)));
    c4 = a7 ? 4'h7 : T4[d[7:5]];
    flip4 = ($countones(c4) != 2) || (c4 == 4'hc);
    if ((rdm && flip4) || (k28 && rd && !flip4)) begin
      c4 = ~c4;
    end
    for (int i = 0; i < 6; i++) begin
      code[i] = c6[5-i];
    end
    for (int i = 0; i < 4; i++) begin
      code[6+i] = c4[3-i];
    end
    return {rdm ^ ($countones(c4) != 2), code};
  endfunction

  logic        rd_reg;
  logic        rd_next;
  logic        rd_in;
  logic [10:0] coded;
  logic [79:0] groups_next;

  always_comb begin
    rd_next = rd_reg;
    rd_in = rd_reg;
    coded = '0;
    groups_next = '0;
    for (int n = 0; n < tx_pcs_pkg::LANES; n++) begin
      if (e.lanes[n]) begin
        if (e.skip[n]) begin
          groups_next[n*10 +: 10] = {e.sel[n], e.val[n],
                                     e.data[n*8 +: 8]}; // [R4] [R6]
        end else begin
          unique case ({e.sel[n], e.val[n]})
            2'b00: rd_in = rd_next; // [R8]
            2'b01: rd_in = ~rd_next; // [R8]
            2'b10: rd_in = 1'b0; // [R7] [R8]
            2'b11: rd_in = 1'b1; // [R7] [R8]
          endcase
          coded = enc_byte(e.data[n*8 +: 8], e.k[n], rd_in); // [R5] [R6]
          groups_next[n*10 +: 10] = coded[9:0];
          rd_next = coded[10]; // [R23]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_reg <= tx_pcs_pkg::RD_RESET;
      e.groups <= '0;
      e.valid_out <= 1'b0;
    end else if (clk_en) begin
      e.valid_out <= e.enable && e.valid_in; // [R9]
      if (e.enable && e.valid_in) begin
        e.groups <= groups_next;
        rd_reg <= rd_next; // [R23]
      end
    end
  end
endmodule

/* File: logic/tx_buf_mem.sv */
// storage of the phase-adjust transmit buffer, registered read
`timescale 1ns/1ps
module tx_buf_mem #(
  parameter int W     = 80,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic clk_en,
  buf_mem_if.mem   m
);
  logic [W-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (clk_en && m.we) begin
      store[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && m.re) begin
      m.rdata <= store[m.raddr];
    end
  end
endmodule

/* File: tb/serdes_tx_pcs_front_end_monitor.sv */
// assertion checker on the ports of the transmit pcs front end
`timescale 1ns/1ps
module serdes_tx_pcs_front_end_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        tx_reset,
  input wire logic        pma_take,
  input wire logic        electrical_idle,
  input wire logic        receiver_detect,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic [79:0] pma_word,
  input wire logic        pma_valid,
  input wire logic        tx_buf_err,
  input wire logic [83:0] driver_settings,
  input wire logic [1:0]  active_set,
  input wire logic        cm_regulation_en
);
  logic       arst;
  logic [1:0] up_cnt;
  logic       ready;
  assign arst = !rst_b || tx_reset;
  assign ready = up_cnt == 2'h3;
  // counts edges since reset release, past the two-flop release
  always_ff @(posedge clk or posedge arst) begin
    if (arst)
      up_cnt <= 2'h0;
    else if (!ready)
      up_cnt <= up_cnt + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (arst);
  chk_err_sticky: assert property (tx_buf_err |=> tx_buf_err)
    else $error("buffer error fell without reset");
  chk_err_cleared: assert property (disable iff (1'b0)
    arst |-> !tx_buf_err && !pma_valid)
    else $error("outputs not cleared in reset");
  chk_status_mirror: assert property (ready &&
    $past(reg_addr) == tx_pcs_pkg::ADDR_STATUS
    |-> reg_rdata == {7'h00, $past(tx_buf_err)})
    else $error("status read differs from buffer error");
  chk_valid_cause: assert property (ready && pma_valid
    |-> $past(pma_take, 2))
    else $error("word valid without a take two cycles before");
  chk_word_stands: assert property (ready && $changed(pma_word)
    |-> pma_valid)
    else $error("word changed without valid");
  chk_set_detect: assert property (ready && $past(receiver_detect)
    |-> active_set == tx_pcs_pkg::SET_DETECT)
    else $error("detect set not applied");
  chk_set_idle: assert property (ready &&
    $past(electrical_idle && !receiver_detect)
    |-> active_set == tx_pcs_pkg::SET_IDLE)
    else $error("idle set not applied");
  chk_set_normal: assert property (ready &&
    $past(!electrical_idle && !receiver_detect)
    |-> active_set == tx_pcs_pkg::SET_NORMAL)
    else $error("normal set not applied");
  chk_cm_loop: assert property (ready && $stable(driver_settings)
    |-> cm_regulation_en ==
        (driver_settings[76:70] != driver_settings[83:77]))
    else $error("regulation enable disagrees with setpoints");
endmodule
bind serdes_tx_pcs_front_end serdes_tx_pcs_front_end_monitor monitor_i (
  .clk, .rst_b, .tx_reset, .pma_take, .electrical_idle, .receiver_detect,
  .reg_addr, .reg_rdata, .pma_word, .pma_valid, .tx_buf_err,
  .driver_settings, .active_set, .cm_regulation_en);

/* File: tb/serdes_tx_pcs_front_end_test.sv */
// self-checking bench for the transmit pcs front end
`timescale 1ns/1ps
module serdes_tx_pcs_front_end_test;
  localparam int DEPTH = 4;
  logic        clk = 1'b0;
  logic        rst_b = 1'b1;
  logic        tx_reset = 1'b0;
  logic        enc_en = 1'b0;
  logic [2:0]  pat = 3'h0;
  logic        inject = 1'b0;
  logic        pol = 1'b0;
  logic        eidle = 1'b0;
  logic        rxdet = 1'b0;
  logic        take_r = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [63:0] tx_data;
  logic        tx_valid, wvalid, err, cm_en;
  logic [7:0]  sel, val, skip, kch, rdata;
  logic [79:0] word;
  logic [83:0] drv;
  logic [1:0]  aset;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  serdes_tx_pcs_front_end #(.DEPTH(DEPTH)) serdes_tx_pcs_front_end_i (
    .clk(clk), .rst_b(rst_b), .tx_reset(tx_reset), .clk_en(1'b1),
    .tx_data(tx_data), .tx_valid(tx_valid),
    .disparity_override_select(sel), .disparity_override_value(val),
    .per_byte_encoder_skip(skip), .encoder_enable_in(enc_en),
    .control_char_flag(kch), .pattern_select(pat),
    .pattern_error_inject(inject), .polarity_invert(pol),
    .electrical_idle(eidle), .receiver_detect(rxdet), .pma_take(take_r),
    .reg_we(we), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .pma_word(word), .pma_valid(wvalid), .tx_buf_err(err),
    .driver_settings(drv), .active_set(aset), .cm_regulation_en(cm_en));

  tx_fabric_model tx_fabric_model_i (
    .clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .sel(sel),
    .val(val), .skip(skip), .kch(kch));

  task automatic check(input logic [79:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic dp_reset();
    tx_reset = 1'b1;
    tick(2);
    tx_reset = 1'b0;
    tick(3);
  endtask

  task automatic reg_wr(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    tick(1);
  endtask

  task automatic reg_rd(input logic [7:0] a, exp);
    addr = a;
    tick(1);
    check({72'h0, rdata}, {72'h0, exp});
  endtask

  task automatic take(output logic [79:0] w);
    take_r = 1'b1;
    tick(1);
    take_r = 1'b0;
    for (int i = 0; i < 4 && wvalid !== 1'b1; i++)
      tick(1);
    check({79'h0, wvalid}, 80'h1);
    w = word;
  endtask

  function automatic logic [79:0] raw(input logic [63:0] d,
      input logic [7:0] s, v, input int lanes);
    logic [79:0] r;
    r = 80'h0;
    for (int n = 0; n < lanes; n++)
      r[10*n +: 10] = {s[n], v[n], d[8*n +: 8]};
    return r;
  endfunction

  task automatic t_regs();
    logic [7:0] dflt [12] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h3f, 8'h00,
                              8'h04, 8'h3f, 8'h00, 8'h00, 8'h0e, 8'h10};
    for (int s = 0; s < 3; s++)
      for (int f = 0; f < 12; f++)
        reg_rd({2'h0, 2'(s), 4'(f)}, dflt[f]);
    reg_rd(8'h30, 8'h03);
    reg_rd(8'h31, 8'h00);
    reg_wr(8'h06, 8'hff);
    reg_rd(8'h06, 8'h07);
    reg_wr(8'h03, 8'h05);
    reg_wr(8'h00, 8'h03);
    reg_rd(8'h00, 8'h03);
    reg_wr(8'h3f, 8'h55);
    reg_rd(8'h3f, 8'h00);
    reg_wr(8'h31, 8'hff);
    reg_rd(8'h31, 8'h00);
  endtask

  task automatic t_raw();
    logic [63:0] d;
    logic [79:0] w, e;
    int          lanes;
    for (int m = 0; m < 4; m++) begin
      lanes = m[1] ? 8 : (m[0] ? 4 : 2);
      d = 64'h8877_6655_4433_2211 + 64'(m);
      pol = (m == 1);
      reg_wr(8'h30, 8'(m));
      tx_fabric_model_i.send(d, 8'ha5 ^ 8'(m), 8'h3c, 8'h00, 8'hff);
      take(w);
      e = raw(d, 8'ha5 ^ 8'(m), 8'h3c, lanes);
      if (pol)
        e = e ^ raw('1, 8'hff, 8'hff, lanes);
      check(w, e);
    end
    pol = 1'b0;
  endtask

  task automatic t_enc();
    logic [79:0] w;
    logic [79:0] e [4] = '{80'ha0d7c, 80'h5f17c, 80'ha0d7c, 80'h96a83};
    dp_reset();
    reg_wr(8'h30, 8'h00);
    enc_en = 1'b1;
    tx_fabric_model_i.send(64'hbcbc, 8'h00, 8'h00, 8'h00, 8'h03);
    tx_fabric_model_i.send(64'hbcbc, 8'h02, 8'h00, 8'h00, 8'h03);
    tx_fabric_model_i.send(64'hbcbc, 8'h00, 8'h01, 8'h00, 8'h03);
    tx_fabric_model_i.send(64'h5abc, 8'h03, 8'h01, 8'h02, 8'h01);
    for (int i = 0; i < 4; i++) begin
      take(w);
      check(w, e[i]);
    end
    enc_en = 1'b0;
  endtask

  task automatic t_buf();
    logic [79:0] w;
    dp_reset();
    for (int i = 0; i <= DEPTH; i++)
      tx_fabric_model_i.send(64'(i), 8'h00, 8'h00, 8'h00, 8'h00);
    tick(1);
    check({79'h0, err}, 80'h1);
    for (int i = 0; i < DEPTH; i++) begin
      take(w);
      check(w, 80'(i));
    end
    reg_rd(8'h31, 8'h01);
    dp_reset();
    check({79'h0, err}, 80'h0);
    take_r = 1'b1;
    tick(1);
    take_r = 1'b0;
    tick(3);
    check({79'h0, err}, 80'h1);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(3);
    check({79'h0, err}, 80'h0);
  endtask

  task automatic t_sets();
    reg_wr(8'h02, 8'h05);
    reg_wr(8'h12, 8'h09);
    reg_wr(8'h22, 8'h0a);
    eidle = 1'b1;
    tick(2);
    check({71'h0, aset, drv[20:14]}, {71'h0, 2'h1, 7'h09});
    rxdet = 1'b1;
    tick(2);
    check({71'h0, aset, drv[20:14]}, {71'h0, 2'h2, 7'h0a});
    eidle = 1'b0;
    rxdet = 1'b0;
    tick(2);
    check({71'h0, aset, drv[20:14]}, {71'h0, 2'h0, 7'h05});
    reg_wr(8'h0a, 8'h10);
    tick(2);
    check({79'h0, cm_en}, 80'h0);
    reg_wr(8'h0a, 8'h0e);
    tick(2);
    check({79'h0, cm_en}, 80'h1);
  endtask

  task automatic pat_word(input logic [2:0] p, input logic pl, inj,
      output logic [79:0] w);
    pat = p;
    pol = pl;
    inject = inj;
    dp_reset();
    take(w);
  endtask

  // first 80 bits of the sequence whose taps are bits hi and hi-1
  function automatic logic [79:0] prbs(input int hi);
    logic [14:0] st;
    logic [79:0] r;
    st = tx_pcs_pkg::PRBS_SEED;
    r = 80'h0;
    for (int i = 0; i < 80; i++) begin
      r[i] = st[hi] ^ st[hi-1];
      st = {st[13:0], r[i]};
    end
    return r;
  endfunction

  task automatic t_pat();
    logic [79:0] w, a;
    pat_word(3'h7, 1'b0, 1'b0, w);
    check(w, 80'hff_ffff_ffff);
    pat_word(3'h7, 1'b1, 1'b0, w);
    check(w, 80'hffff_ffff_ff00_0000_0000);
    for (int p = 3; p < 6; p++) begin
      pat_word(3'(p), 1'b0, 1'b0, w);
      check(w, 80'h0);
    end
    pat_word(3'h6, 1'b0, 1'b0, w);
    check({79'h0, w === {20{4'h5}} || w === {20{4'ha}}}, 80'h1);
    pat_word(3'h1, 1'b0, 1'b0, a);
    check(a, prbs(6));
    pat_word(3'h1, 1'b0, 1'b1, w);
    check(w, a ^ 80'h1);
    pat_word(3'h2, 1'b0, 1'b0, w);
    check({79'h0, w !== a}, 80'h1);
    check(w, prbs(14));
  endtask

  initial begin
    #1;
    rst_b = 1'b0;
    tick(10);
    rst_b = 1'b1;
    tick(3);
    t_regs();
    t_raw();
    t_enc();
    t_buf();
    t_sets();
    t_pat();
    summarize();
  end
endmodule

/* File: tb/tx_fabric_model.sv */
// fabric-side model that offers words to the transmit lanes
`timescale 1ns/1ps
module tx_fabric_model (
  input  wire logic        clk,
  output      logic [63:0] tx_data,
  output      logic        tx_valid,
  output      logic [7:0]  sel,
  output      logic [7:0]  val,
  output      logic [7:0]  skip,
  output      logic [7:0]  kch
);
  initial begin
    tx_data = 64'h0;
    tx_valid = 1'b0;
    sel = 8'h00;
    val = 8'h00;
    skip = 8'h00;
    kch = 8'h00;
  end
  // one word for one cycle, then junk on the released lines
  task automatic send(input logic [63:0] d, input logic [7:0] s, v, sk, k);
    @(posedge clk);
    #1;
    tx_data = d;
    sel = s;
    val = v;
    skip = sk;
    kch = k;
    tx_valid = 1'b1;
    @(posedge clk);
    #1;
    tx_valid = 1'b0;
    tx_data = ~d;
    sel = ~s;
    val = ~v;
    skip = ~sk;
    kch = ~k;
  endtask
endmodule
